// file: logic/reader_dual_countdown_timers.sv
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ns
// Notes on behaviour
// RQ1 - start event loads reload into counter
// RQ2 - reload writes affect only next start
// RQ3 - first count readable at 0x12, 0x13
// RQ4 - host avoids count reads during reception
// RQ5 - stop-on-receive halts after four received bits
// RQ6 - trimming mode ignores stop-on-receive
// RQ7 - mode 00 starts only by software
// RQ8 - mode 01 starts at transmission end
// RQ9 - modes 10/11 trim, start/stop on edges
// RQ10 - auto-restart reloads at zero, keeps counting
// RQ11 - without auto-restart stop and hold zero
// RQ12 - second underflow sets interrupt request flag
// RQ13 - select 00 fast tick, 01 slow tick
// RQ14 - select 10/11 cascades sibling underflows
// RQ15 - second control layout at 0x14
// RQ16 - second reload and count bytes mapped
// RQ17 - global low nibble masks running writes
// RQ18 - global upper nibble reports running timers
// RQ19 - first reload high at 0x10
// RQ20 - sixteen-bit counter, one step per tick
module reader_dual_countdown_timers (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic tx_end,
	input wire logic rx_active,
	input wire logic rx_bit,
	input wire logic lfo_pin,
	input wire logic third_underflow,
	input wire logic [1:0] other_running,
	output logic second_timer_irq_flag
);
	import timer_pkg::*;

	typedef struct packed {
		timer_t [1:0] tmr;
		logic irq;
		logic [2:0] rx_count;
		logic rx_active_q;
		logic lfo_s1;
		logic lfo_s2;
		logic lfo_s3;
		logic [7:0] rdata;
	} top_state_t;

	top_state_t q;
	top_state_t d;
	logic lfo_rise;
	logic rx_fourth;
	logic glob_wr;
	logic [2:0] rx_base;
	logic [1:0] tick;

	tick_if ticks ();

	tick_divider u_div (
		.clock(clock),
		.rst_n(rst_n),
		.ticks(ticks.source)
	);

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic tick_sel(ctrl_t c, logic fast, logic slow, logic ca, logic cb);
		logic r;
		r = 1'b0;
		unique case (c.clock_select_field)
			CLK_FAST: r = fast; // see RQ13
			CLK_SLOW: r = slow; // see RQ13
			CLK_CASCADE_A: r = ca; // see RQ14
			CLK_CASCADE_B: r = cb; // see RQ14
		endcase
		return r;
	endfunction : tick_sel

	function automatic timer_t timer_step(timer_t t, logic tk, logic txe, logic rx4,
			logic edge_in, logic sw_wr, logic sw_val);
		timer_t n;
		logic trim;
		n = t;
		n.underflow = 1'b0;
		trim = t.ctrl.start_mode_field inside {MODE_TRIM_NO_UF, MODE_TRIM_UF};
		if (t.running && tk) begin
			if (t.count != COUNT_ZERO) begin
				n.count = t.count - COUNT_STEP; // see RQ20
			end else if (t.ctrl.start_mode_field != MODE_TRIM_NO_UF) begin
				n.underflow = 1'b1;
				if (t.ctrl.auto_restart) begin
					n.count = t.reload; // see RQ10
				end else begin
					n.running = 1'b0; // see RQ11
				end
			end
		end
		if (!trim && t.ctrl.stop_on_receive && rx4) begin
			n.running = 1'b0; // see RQ5, see RQ6
		end
		if (trim && edge_in) begin
			n.running = !t.running; // see RQ9
			if (!t.running) begin
				n.count = t.reload;
			end
		end
		if (t.ctrl.start_mode_field == MODE_TX_END && txe) begin
			n.running = 1'b1; // see RQ8
			n.count = t.reload; // see RQ1
		end
		if (sw_wr) begin
			n.running = sw_val; // see RQ7, see RQ17
			if (sw_val) begin
				n.count = t.reload; // see RQ1
			end
		end
		return n;
	endfunction : timer_step

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		d = q;
		d.rdata = 8'h00;
		d.lfo_s1 = lfo_pin;
		d.lfo_s2 = q.lfo_s1;
		d.lfo_s3 = q.lfo_s2;
		lfo_rise = q.lfo_s2 && !q.lfo_s3;

		// received-bit counter restarts with each reception
		d.rx_active_q = rx_active;
		rx_base = (rx_active && !q.rx_active_q) ? 3'h0 : q.rx_count;
		d.rx_count = rx_base;
		if (rx_active && rx_bit && rx_base != RX_STOP_BITS) begin
			d.rx_count = rx_base + 3'h1;
		end
		rx_fourth = rx_active && rx_bit && (rx_base == RX_STOP_BITS - 3'h1); // see RQ5

		tick[FIRST] = tick_sel(q.tmr[FIRST].ctrl, ticks.fast_tick, ticks.slow_tick,
			third_underflow, q.tmr[SECOND].underflow);
		tick[SECOND] = tick_sel(q.tmr[SECOND].ctrl, ticks.fast_tick, ticks.slow_tick,
			q.tmr[FIRST].underflow, third_underflow); // see RQ14

		glob_wr = reg_wr && reg_addr == ADDR_GLOBAL;
		for (int i = 0; i < 2; i++) begin
			d.tmr[i] = timer_step(q.tmr[i], tick[i], tx_end, rx_fourth, lfo_rise,
				glob_wr && reg_wdata[i], reg_wdata[RUN_LSB + i]); // see RQ17
		end

		// register writes; reloads land in storage only
		if (reg_wr) begin
			unique case (reg_addr)
				ADDR_FIRST_CTRL: d.tmr[FIRST].ctrl = ctrl_t'(reg_wdata & CTRL_WRITABLE);
				ADDR_FIRST_RELOAD_HIGH: d.tmr[FIRST].reload[15:8] = reg_wdata; // see RQ19
				ADDR_FIRST_RELOAD_LOW: d.tmr[FIRST].reload[7:0] = reg_wdata; // see RQ2
				ADDR_SECOND_CTRL: d.tmr[SECOND].ctrl = ctrl_t'(reg_wdata & CTRL_WRITABLE); // see RQ15
				ADDR_SECOND_RELOAD_HIGH: d.tmr[SECOND].reload[15:8] = reg_wdata; // see RQ16
				ADDR_SECOND_RELOAD_LOW: d.tmr[SECOND].reload[7:0] = reg_wdata; // see RQ2
				ADDR_STATUS: begin
					if (reg_wdata[STATUS_IRQ_BIT]) begin
						d.irq = 1'b0;
					end
				end
				default: ;
			endcase
		end
		// a new underflow beats a clear in the same cycle
		if (d.tmr[SECOND].underflow) begin
			d.irq = 1'b1; // see RQ12
		end

		if (reg_rd) begin
			unique case (reg_addr)
				ADDR_GLOBAL: d.rdata = {other_running, q.tmr[SECOND].running,
					q.tmr[FIRST].running, 4'h0}; // see RQ18
				ADDR_FIRST_CTRL: d.rdata = q.tmr[FIRST].ctrl;
				ADDR_FIRST_RELOAD_HIGH: d.rdata = q.tmr[FIRST].reload[15:8];
				ADDR_FIRST_RELOAD_LOW: d.rdata = q.tmr[FIRST].reload[7:0];
				ADDR_FIRST_COUNT_HIGH: d.rdata = q.tmr[FIRST].count[15:8]; // see RQ3
				ADDR_FIRST_COUNT_LOW: d.rdata = q.tmr[FIRST].count[7:0]; // see RQ3
				ADDR_SECOND_CTRL: d.rdata = q.tmr[SECOND].ctrl; // see RQ15
				ADDR_SECOND_RELOAD_HIGH: d.rdata = q.tmr[SECOND].reload[15:8];
				ADDR_SECOND_RELOAD_LOW: d.rdata = q.tmr[SECOND].reload[7:0];
				ADDR_SECOND_COUNT_HIGH: d.rdata = q.tmr[SECOND].count[15:8]; // see RQ16
				ADDR_SECOND_COUNT_LOW: d.rdata = q.tmr[SECOND].count[7:0]; // see RQ16
				ADDR_STATUS: d.rdata = {7'h00, q.irq};
				default: d.rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign reg_rdata = q.rdata;
	assign second_timer_irq_flag = q.irq;

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_n);

	sequence s_global_start_second;
		glob_wr && reg_wdata[SECOND] && reg_wdata[RUN_LSB + SECOND];
	endsequence

	sequence s_trim_edge_idle;
		q.tmr[SECOND].ctrl.start_mode_field inside {MODE_TRIM_NO_UF, MODE_TRIM_UF}
			&& !q.tmr[SECOND].running && lfo_rise && !glob_wr && !tx_end;
	endsequence

	property p_start_load;
		s_global_start_second |=> q.tmr[SECOND].running
			&& q.tmr[SECOND].count == $past(q.tmr[SECOND].reload);
	endproperty
	a_start_load: assert property (p_start_load) else $error("start did not load reload"); // see RQ1

	property p_reload_hold;
		reg_wr && reg_addr == ADDR_SECOND_RELOAD_LOW && q.tmr[SECOND].running && !tx_end
			&& !lfo_rise |=> q.tmr[SECOND].count == $past(q.tmr[SECOND].count)
			|| q.tmr[SECOND].count == $past(q.tmr[SECOND].count) - COUNT_STEP
			|| q.tmr[SECOND].count == $past(q.tmr[SECOND].reload);
	endproperty
	a_reload_hold: assert property (p_reload_hold) else $error("reload write moved count"); // see RQ2

	property p_count_read;
		reg_rd && reg_addr == ADDR_FIRST_COUNT_LOW
			|=> reg_rdata == $past(q.tmr[FIRST].count[7:0]) ##1 reg_rdata == 8'h00 || $past(reg_rd);
	endproperty
	a_count_read: assert property (p_count_read) else $error("count read mismatch"); // see RQ3

	property p_rx_stop;
		rx_fourth && q.tmr[SECOND].ctrl.stop_on_receive && !glob_wr && !tx_end
			&& !q.tmr[SECOND].ctrl.start_mode_field[1] |=> !q.tmr[SECOND].running;
	endproperty
	a_rx_stop: assert property (p_rx_stop) else $error("no stop after four bits"); // see RQ5

	property p_trim_ignore;
		rx_fourth && q.tmr[SECOND].ctrl.start_mode_field == MODE_TRIM_NO_UF
			&& q.tmr[SECOND].running && !lfo_rise && !glob_wr |=> q.tmr[SECOND].running;
	endproperty
	a_trim_ignore: assert property (p_trim_ignore) else $error("trim stopped on receive"); // see RQ6

	property p_no_self_start;
		q.tmr[SECOND].ctrl.start_mode_field == MODE_SOFTWARE && !q.tmr[SECOND].running
			&& !glob_wr |=> !q.tmr[SECOND].running;
	endproperty
	a_no_self_start: assert property (p_no_self_start) else $error("started by itself"); // see RQ7

	property p_tx_start;
		q.tmr[SECOND].ctrl.start_mode_field == MODE_TX_END && tx_end && !glob_wr
			|=> q.tmr[SECOND].running && q.tmr[SECOND].count == $past(q.tmr[SECOND].reload);
	endproperty
	a_tx_start: assert property (p_tx_start) else $error("no start at tx end"); // see RQ8

	property p_trim_edge;
		s_trim_edge_idle |=> q.tmr[SECOND].running ##2 q.tmr[SECOND].running || $past(lfo_rise)
			|| $past(glob_wr) || $past(q.tmr[SECOND].underflow, 1) || $past(rx_fourth)
			|| q.tmr[SECOND].underflow;
	endproperty
	a_trim_edge: assert property (p_trim_edge) else $error("edge did not start trim"); // see RQ9

	property p_auto_restart;
		q.tmr[SECOND].underflow && $past(q.tmr[SECOND].ctrl.auto_restart) && !$past(glob_wr)
			&& !$past(rx_fourth) && !$past(lfo_rise) |-> q.tmr[SECOND].running
			&& q.tmr[SECOND].count == $past(q.tmr[SECOND].reload);
	endproperty
	a_auto_restart: assert property (p_auto_restart) else $error("no auto restart"); // see RQ10

	property p_stop_zero;
		q.tmr[SECOND].underflow && !$past(q.tmr[SECOND].ctrl.auto_restart) && !$past(glob_wr)
			&& !$past(tx_end) && !$past(lfo_rise)
			|-> !q.tmr[SECOND].running && q.tmr[SECOND].count == COUNT_ZERO;
	endproperty
	a_stop_zero: assert property (p_stop_zero) else $error("did not stop at zero"); // see RQ11

	property p_irq;
		q.tmr[SECOND].underflow |-> second_timer_irq_flag;
	endproperty
	a_irq: assert property (p_irq) else $error("underflow without flag"); // see RQ12

	property p_cascade;
		q.tmr[SECOND].ctrl.clock_select_field == CLK_CASCADE_A && q.tmr[SECOND].running
			&& q.tmr[FIRST].underflow && q.tmr[SECOND].count != COUNT_ZERO && !glob_wr
			&& !tx_end && !lfo_rise |=> q.tmr[SECOND].count == $past(q.tmr[SECOND].count) - COUNT_STEP;
	endproperty
	a_cascade: assert property (p_cascade) else $error("cascade tick lost"); // see RQ14

	property p_mask;
		glob_wr && !reg_wdata[SECOND] && reg_wdata[RUN_LSB + SECOND] && !q.tmr[SECOND].running
			&& !tx_end && !lfo_rise |=> !q.tmr[SECOND].running;
	endproperty
	a_mask: assert property (p_mask) else $error("masked write changed running"); // see RQ17

	property p_global_read;
		reg_rd && reg_addr == ADDR_GLOBAL |=> reg_rdata[RUN_LSB + SECOND]
			== $past(q.tmr[SECOND].running) && reg_rdata[3:0] == 4'h0;
	endproperty
	a_global_read: assert property (p_global_read) else $error("running status wrong"); // see RQ18

endmodule : reader_dual_countdown_timers

// file: common/timer_pkg.sv
package timer_pkg;

	// ----------------------------------------
	// clock and tick rates
	// ----------------------------------------
	localparam longint unsigned CLK_HZ = 64'd50_000_000;
	localparam longint unsigned FAST_HZ = 64'd13_560_000;
	localparam longint unsigned SLOW_HZ = 64'd211_875;
	localparam int ACC_W = 24;
	localparam logic [ACC_W-1:0] FAST_INC = ACC_W'((FAST_HZ << ACC_W) / CLK_HZ);
	localparam logic [ACC_W-1:0] SLOW_INC = ACC_W'((SLOW_HZ << ACC_W) / CLK_HZ);

	// ----------------------------------------
	// register offsets
	// ----------------------------------------
	localparam logic [7:0] ADDR_GLOBAL = 8'h0e;
	localparam logic [7:0] ADDR_FIRST_CTRL = 8'h0f;
	localparam logic [7:0] ADDR_FIRST_RELOAD_HIGH = 8'h10;
	localparam logic [7:0] ADDR_FIRST_RELOAD_LOW = 8'h11;
	localparam logic [7:0] ADDR_FIRST_COUNT_HIGH = 8'h12;
	localparam logic [7:0] ADDR_FIRST_COUNT_LOW = 8'h13;
	localparam logic [7:0] ADDR_SECOND_CTRL = 8'h14;
	localparam logic [7:0] ADDR_SECOND_RELOAD_HIGH = 8'h15;
	localparam logic [7:0] ADDR_SECOND_RELOAD_LOW = 8'h16;
	localparam logic [7:0] ADDR_SECOND_COUNT_HIGH = 8'h17;
	localparam logic [7:0] ADDR_SECOND_COUNT_LOW = 8'h18;
	localparam logic [7:0] ADDR_STATUS = 8'h20;

	// ----------------------------------------
	// field layouts and values
	// ----------------------------------------
	localparam int FIRST = 0;
	localparam int SECOND = 1;
	localparam int RUN_LSB = 4;
	localparam logic [7:0] CTRL_WRITABLE = 8'hbb;
	localparam logic [2:0] RX_STOP_BITS = 3'h4;
	localparam logic [15:0] COUNT_ZERO = 16'h0000;
	localparam logic [15:0] COUNT_STEP = 16'h0001;
	localparam int STATUS_IRQ_BIT = 0;

	typedef enum logic [1:0] {
		MODE_SOFTWARE = 2'h0,
		MODE_TX_END = 2'h1,
		MODE_TRIM_NO_UF = 2'h2,
		MODE_TRIM_UF = 2'h3
	} start_mode_t;

	typedef enum logic [1:0] {
		CLK_FAST = 2'h0,
		CLK_SLOW = 2'h1,
		CLK_CASCADE_A = 2'h2,
		CLK_CASCADE_B = 2'h3
	} clk_sel_t;

	typedef struct packed {
		logic stop_on_receive;
		logic rsv6;
		start_mode_t start_mode_field;
		logic auto_restart;
		logic rsv2;
		clk_sel_t clock_select_field;
	} ctrl_t;

	typedef struct packed {
		logic running;
		logic underflow;
		logic [15:0] count;
		logic [15:0] reload;
		ctrl_t ctrl;
	} timer_t;

endpackage : timer_pkg

// file: common/tick_if.sv
`timescale 1ns/1ns
interface tick_if;
	logic fast_tick;
	logic slow_tick;
	modport source (output fast_tick, output slow_tick);
	modport sink (input fast_tick, input slow_tick);
endinterface : tick_if

// file: logic/tick_divider.sv
`timescale 1ns/1ns
module tick_divider (
	input wire logic clock,
	input wire logic rst_n,
	tick_if.source ticks
);
	import timer_pkg::*;

	typedef struct packed {
		logic [ACC_W-1:0] acc_fast;
		logic [ACC_W-1:0] acc_slow;
		logic fast;
		logic slow;
	} div_state_t;

	div_state_t q;
	div_state_t d;

	// ----------------------------------------
	// fractional dividers, carry is the tick
	// ----------------------------------------
	always_comb begin
		d = q;
		{d.fast, d.acc_fast} = {1'b0, q.acc_fast} + {1'b0, FAST_INC};
		{d.slow, d.acc_slow} = {1'b0, q.acc_slow} + {1'b0, SLOW_INC};
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign ticks.fast_tick = q.fast;
	assign ticks.slow_tick = q.slow;

endmodule : tick_divider

// file: test/reader_dual_countdown_timers_tb.sv
`timescale 1ns/1ns
module reader_dual_countdown_timers_tb;
	import timer_pkg::*;
	logic clock, rst_n, reg_wr, reg_rd, tx_end, rx_active, rx_bit;
	logic lfo_pin, third_underflow, second_timer_irq_flag;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, hi, lo;
	logic [1:0] other_running;
	int bad_count, cmp_count, cycles;

	reader_dual_countdown_timers dut (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.tx_end(tx_end), .rx_active(rx_active), .rx_bit(rx_bit), .lfo_pin(lfo_pin),
		.third_underflow(third_underflow), .other_running(other_running),
		.second_timer_irq_flag(second_timer_irq_flag));

	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task summarize;
		$display("comparisons %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : summarize

	task check(input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clock);
		reg_wr <= 1'b0;
		// let the register update settle before anyone looks at outputs
		#1;
	endtask : wr

	task rdr(input logic [7:0] a, output logic [7:0] d);
		@(posedge clock);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask : rdr

	// one-cycle pulse on tx_end, rx_bit or third_underflow, then let it land
	task pulse(input int w);
		@(posedge clock);
		case (w)
			0: tx_end <= 1'b1;
			1: rx_bit <= 1'b1;
			default: third_underflow <= 1'b1;
		endcase
		@(posedge clock);
		tx_end <= 1'b0;
		rx_bit <= 1'b0;
		third_underflow <= 1'b0;
		repeat (3) @(posedge clock);
	endtask : pulse

	task count2(input logic [15:0] exp);
		rdr(ADDR_SECOND_COUNT_HIGH, hi);
		rdr(ADDR_SECOND_COUNT_LOW, lo);
		check({hi, lo}, exp);
	endtask : count2

	task running(input logic [1:0] exp);
		rdr(ADDR_GLOBAL, hi);
		check(hi, {other_running, exp, 4'h0});
	endtask : running

	task lfo_rise;
		@(posedge clock);
		lfo_pin <= 1'b1;
		repeat (4) @(posedge clock);
		lfo_pin <= 1'b0;
		repeat (4) @(posedge clock);
	endtask : lfo_rise

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task t_regs;
		rdr(ADDR_SECOND_CTRL, hi);
		check(hi, 8'h00);
		check(second_timer_irq_flag, 1'b0);
		rdr(8'h30, hi);
		check(hi, 8'h00);
		wr(ADDR_SECOND_CTRL, 8'hff);
		rdr(ADDR_SECOND_CTRL, hi);
		check(hi, CTRL_WRITABLE);
		wr(ADDR_SECOND_CTRL, 8'h03);
		wr(ADDR_SECOND_RELOAD_HIGH, 8'h12);
		wr(ADDR_SECOND_RELOAD_LOW, 8'h34);
		rdr(ADDR_SECOND_RELOAD_HIGH, hi);
		rdr(ADDR_SECOND_RELOAD_LOW, lo);
		check({hi, lo}, 16'h1234);
		wr(ADDR_SECOND_COUNT_HIGH, 8'h55);
		count2(16'h0000);
		$display("test regs done");
	endtask : t_regs

	task t_start;
		wr(ADDR_GLOBAL, 8'h22);
		count2(16'h1234);
		running(2'b10);
		wr(ADDR_SECOND_RELOAD_LOW, 8'h56);
		count2(16'h1234);
		wr(ADDR_GLOBAL, 8'h22);
		count2(16'h1256);
		wr(ADDR_GLOBAL, 8'h00);
		running(2'b10);
		wr(ADDR_GLOBAL, 8'h02);
		running(2'b00);
		wr(ADDR_GLOBAL, 8'h20);
		running(2'b00);
		wr(ADDR_FIRST_RELOAD_HIGH, 8'hab);
		wr(ADDR_FIRST_RELOAD_LOW, 8'hcd);
		wr(ADDR_FIRST_CTRL, 8'h03);
		wr(ADDR_GLOBAL, 8'h11);
		wr(ADDR_FIRST_COUNT_LOW, 8'h00);
		rdr(ADDR_FIRST_COUNT_HIGH, hi);
		rdr(ADDR_FIRST_COUNT_LOW, lo);
		check({hi, lo}, 16'habcd);
		running(2'b01);
		wr(ADDR_GLOBAL, 8'h01);
		$display("test start done");
	endtask : t_start

	task t_cascade;
		wr(ADDR_SECOND_RELOAD_HIGH, 8'h00);
		wr(ADDR_SECOND_RELOAD_LOW, 8'h02);
		wr(ADDR_GLOBAL, 8'h22);
		for (int i = 1; i >= 0; i--) begin
			pulse(2);
			count2(16'(i));
		end
		check(second_timer_irq_flag, 1'b0);
		pulse(2);
		check(second_timer_irq_flag, 1'b1);
		running(2'b00);
		count2(16'h0000);
		wr(ADDR_STATUS, 8'h01);
		check(second_timer_irq_flag, 1'b0);
		wr(ADDR_SECOND_CTRL, 8'h0b);
		wr(ADDR_GLOBAL, 8'h22);
		repeat (3) pulse(2);
		count2(16'h0002);
		running(2'b10);
		check(second_timer_irq_flag, 1'b1);
		wr(ADDR_STATUS, 8'h01);
		wr(ADDR_GLOBAL, 8'h02);
		// first timer underflows on every pulse, second counts those underflows
		wr(ADDR_FIRST_RELOAD_HIGH, 8'h00);
		wr(ADDR_FIRST_RELOAD_LOW, 8'h00);
		wr(ADDR_FIRST_CTRL, 8'h0a);
		wr(ADDR_SECOND_CTRL, 8'h02);
		wr(ADDR_GLOBAL, 8'h33);
		pulse(2);
		count2(16'h0001);
		wr(ADDR_GLOBAL, 8'h03);
		$display("test cascade done");
	endtask : t_cascade

	task t_modes;
		wr(ADDR_SECOND_CTRL, 8'h03);
		pulse(0);
		running(2'b00);
		wr(ADDR_SECOND_CTRL, 8'h13);
		pulse(0);
		running(2'b10);
		count2(16'h0002);
		rx_active <= 1'b1;
		wr(ADDR_SECOND_CTRL, 8'h93);
		repeat (3) pulse(1);
		running(2'b10);
		pulse(1);
		running(2'b00);
		rx_active <= 1'b0; // counts are read only outside reception
		wr(ADDR_SECOND_CTRL, 8'ha3);
		wr(ADDR_GLOBAL, 8'h22);
		rx_active <= 1'b1;
		repeat (4) pulse(1);
		running(2'b10);
		rx_active <= 1'b0;
		wr(ADDR_GLOBAL, 8'h02);
		for (int m = 2; m < 4; m++) begin
			wr(ADDR_SECOND_CTRL, {2'h0, 2'(m), 4'h3});
			lfo_rise();
			running(2'b10);
			count2(16'h0002);
			lfo_rise();
			running(2'b00);
		end
		$display("test modes done");
	endtask : t_modes

	task t_ticks;
		int n, exp, got;
		for (int s = 0; s < 2; s++) begin
			n = s ? 2360 : 100;
			exp = int'((longint'(n + 2) * (s ? SLOW_HZ : FAST_HZ)) / CLK_HZ);
			wr(ADDR_SECOND_CTRL, {6'h0, 2'(s)});
			wr(ADDR_SECOND_RELOAD_HIGH, 8'h01);
			wr(ADDR_SECOND_RELOAD_LOW, 8'h00);
			wr(ADDR_GLOBAL, 8'h22);
			repeat (n) @(posedge clock);
			rdr(ADDR_SECOND_COUNT_LOW, lo);
			got = 256 - int'(lo);
			check(got >= exp - 2 && got <= exp + 2, 1'b1);
			wr(ADDR_GLOBAL, 8'h02);
		end
		$display("test ticks done");
	endtask : t_ticks

	// ----------------------------------------
	// clock, reset, sequence and timeout
	// ----------------------------------------
	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end

	always @(posedge clock) begin
		cycles++;
		if (cycles == 20000) begin
			bad_count++;
			summarize();
		end
	end

	initial begin
		rst_n = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		tx_end = 1'b0;
		rx_active = 1'b0;
		rx_bit = 1'b0;
		lfo_pin = 1'b0;
		third_underflow = 1'b0;
		other_running = 2'b10;
		repeat (2) @(posedge clock);
		rst_n <= 1'b1;
		t_regs();
		t_start();
		t_cascade();
		t_modes();
		t_ticks();
		summarize();
	end
endmodule : reader_dual_countdown_timers_tb
